// file: srw_cpu.sv
// supervised processor: strobes the watchdog while running
`timescale 1ns/1ps
module srw_cpu
(
  // clock and control
  input  wire logic        i_sys_clk,
  input  wire logic        i_run,
  input  wire logic [31:0] i_gap,
  // processor side
  input  wire logic        i_reset,
  output logic             o_kick_n
);
  logic [31:0] cnt_r = '0;
  initial o_kick_n = 1'b1;
  always @(posedge i_sys_clk)
  begin
    cnt_r    <= (!i_run || i_reset || cnt_r == i_gap) ? '0 : cnt_r + 1;
    o_kick_n <= !(i_run && cnt_r < 4);
  end
endmodule

// file: srw_pkg.sv
// constants and carrier types for the reset supervisor
package srw_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned TICK_NS         = 1_000_000;
  localparam int unsigned CLK_NS          = 20;
  localparam int unsigned TICK_CYC        = TICK_NS / CLK_NS;
  localparam int unsigned TICK_W          = 16;

  localparam int unsigned DEBOUNCE_MS     = 40;
  localparam int unsigned STRETCH_MS      = 250;
  localparam int unsigned WD_SHORT_MS     = 150;
  localparam int unsigned WD_MID_MS       = 600;
  localparam int unsigned WD_LONG_MS      = 1200;
  localparam int unsigned MS_W            = 11;

  localparam logic [MS_W-1:0] DEBOUNCE_TICKS = MS_W'(DEBOUNCE_MS);
  localparam logic [MS_W-1:0] STRETCH_TICKS  = MS_W'(STRETCH_MS);
  localparam logic [MS_W-1:0] WD_SHORT_TICKS = MS_W'(WD_SHORT_MS);
  localparam logic [MS_W-1:0] WD_MID_TICKS   = MS_W'(WD_MID_MS);
  localparam logic [MS_W-1:0] WD_LONG_TICKS  = MS_W'(WD_LONG_MS);

  // three-level select, resolved off chip into two levels
  typedef struct packed {
    logic tie_high;
    logic tie_low;
  } srw_tsel_s;

  // synchronised external inputs
  typedef struct packed {
    logic      supply_low;
    logic      margin_sel;
    logic      pushbutton_request_n;
    logic      watchdog_kick_n;
    srw_tsel_s tsel;
  } srw_in_s;

  localparam int unsigned IN_W = $bits(srw_in_s);

  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_SUPPLY  = 4'b0010,
    ST_BUTTON  = 4'b0100,
    ST_STRETCH = 4'b1000
  } srw_state_e;

endpackage

// file: srw_supervisor.sv
// reset supervisor: supply, push-button and watchdog reset merge
`timescale 1ns/1ps
module srw_supervisor
#(
  // clock cycles per time-base tick; a bench may shorten it
  parameter int unsigned TICK_DIV = srw_pkg::TICK_CYC
)
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  // supply monitor
  input  wire logic i_supply_low,
  input  wire logic i_supply_margin_select,
  output logic      o_supply_margin_wide,
  // push-button and watchdog
  input  wire logic i_pushbutton_request_n,
  input  wire logic i_watchdog_kick_n,
  input  wire logic i_timeout_select_high,
  input  wire logic i_timeout_select_low,
  // processor reset
  output logic      o_reset,
  output logic      o_reset_n,
  output logic      o_reset_n_oe,
  output logic      o_reset_n_out
);
  import srw_pkg::*;

  srw_in_s            raw_in;
  srw_in_s            syn;
  srw_state_e         state_r;
  srw_state_e         state_nxt;
  logic [TICK_W-1:0]  pre_r;
  logic [TICK_W-1:0]  pre_nxt;
  logic               tick;
  logic [MS_W-1:0]    deb_r;
  logic [MS_W-1:0]    deb_nxt;
  logic [MS_W-1:0]    str_r;
  logic [MS_W-1:0]    str_nxt;
  logic [MS_W-1:0]    wd_r;
  logic [MS_W-1:0]    wd_nxt;
  logic               kick_d_r;
  logic               kick_d_nxt;
  logic               kick_fall;
  logic               btn_held;
  logic               wd_expire;
  logic               rst_r;
  logic               rst_nxt;
  logic               margin_r;
  logic               margin_nxt;
  logic [MS_W-1:0]    wd_limit;

  // decode of the three-level select
  function automatic logic [MS_W-1:0] wd_period(input srw_tsel_s s);
    logic [MS_W-1:0] p;
    p = WD_MID_TICKS;
    if (s.tie_low)
      p = WD_SHORT_TICKS;
    else if (s.tie_high)
      p = WD_LONG_TICKS;
    return p;
  endfunction

  assign raw_in.supply_low           = i_supply_low;
  assign raw_in.margin_sel           = i_supply_margin_select;
  assign raw_in.pushbutton_request_n = i_pushbutton_request_n;
  assign raw_in.watchdog_kick_n      = i_watchdog_kick_n;
  assign raw_in.tsel.tie_high        = i_timeout_select_high;
  assign raw_in.tsel.tie_low         = i_timeout_select_low;

  srw_sync #(
    .W (IN_W)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (raw_in),
    .o_sync    (syn)
  );

  always_comb
  begin
    tick    = (pre_r == TICK_W'(TICK_DIV - 1));
    pre_nxt = tick ? '0 : pre_r + TICK_W'(1);
  end

  assign wd_limit = wd_period(syn.tsel);

  // margin select forwarded to the analog comparator trim
  assign margin_nxt = syn.margin_sel;

  always_comb
  begin
    kick_d_nxt = syn.watchdog_kick_n;
    kick_fall  = kick_d_r & ~syn.watchdog_kick_n;
  end

  // debounce: count ms of continuous low
  always_comb
  begin
    deb_nxt = deb_r;
    if (syn.pushbutton_request_n)
      deb_nxt = '0;
    else if (tick && deb_r != DEBOUNCE_TICKS + MS_W'(1))
      deb_nxt = deb_r + MS_W'(1);
    // one extra tick covers the partial first ms
    btn_held = (deb_r == DEBOUNCE_TICKS + MS_W'(1));
  end

  // watchdog counter, runs only while outputs are released
  always_comb
  begin
    wd_nxt    = wd_r;
    wd_expire = 1'b0;
    if (syn.supply_low)
      wd_nxt = '0;
    // held at zero during reset, so restart at release
    else if (state_r != ST_RUN)
      wd_nxt = '0;
    else if (kick_fall)
      wd_nxt = '0;
    else if (tick)
    begin
      if (wd_r + MS_W'(1) >= wd_limit)
      begin
        wd_expire = 1'b1;
        wd_nxt    = '0;
      end
      else
        wd_nxt = wd_r + MS_W'(1);
    end
  end

  // reset sequencer
  always_comb
  begin
    state_nxt = state_r;
    str_nxt   = str_r;
    case (state_r)
      ST_RUN:
      begin
        str_nxt = '0;
        if (syn.supply_low)
          state_nxt = ST_SUPPLY;
        else if (btn_held)
          state_nxt = ST_BUTTON;
        else if (wd_expire)
          state_nxt = ST_STRETCH;
      end
      ST_SUPPLY:
      begin
        str_nxt = '0;
        if (!syn.supply_low)
          state_nxt = ST_STRETCH;
      end
      ST_BUTTON:
      begin
        str_nxt = '0;
        if (syn.supply_low)
          state_nxt = ST_SUPPLY;
        else if (syn.pushbutton_request_n)
          state_nxt = ST_STRETCH;
      end
      ST_STRETCH:
      begin
        // a supply low or a held button restarts the wait
        if (syn.supply_low)
        begin
          state_nxt = ST_SUPPLY;
          str_nxt   = '0;
        end
        else if (!syn.pushbutton_request_n && btn_held)
        begin
          state_nxt = ST_BUTTON;
          str_nxt   = '0;
        end
        else if (tick)
        begin
          // one extra tick covers the partial first ms
          if (str_r == STRETCH_TICKS)
            state_nxt = ST_RUN;
          else
            str_nxt = str_r + MS_W'(1);
        end
      end
      default:
      begin
        state_nxt = ST_SUPPLY;
        str_nxt   = '0;
      end
    endcase
    rst_nxt = (state_nxt != ST_RUN);
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pre_r    <= '0;
      deb_r    <= '0;
      wd_r     <= '0;
      str_r    <= '0;
      // synchroniser leaves reset low: no false edge on its rise
      kick_d_r <= 1'b0;
      // hold the processor in reset until supply is seen good
      state_r  <= ST_SUPPLY;
      rst_r    <= 1'b1;
      margin_r <= 1'b0;
    end
    else
    begin
      pre_r    <= pre_nxt;
      deb_r    <= deb_nxt;
      wd_r     <= wd_nxt;
      str_r    <= str_nxt;
      kick_d_r <= kick_d_nxt;
      state_r  <= state_nxt;
      rst_r    <= rst_nxt;
      margin_r <= margin_nxt;
    end
  end

  always_comb
  begin
    o_reset       = rst_r;
    o_reset_n     = ~rst_r;
    // open drain: pull low only while reset
    o_reset_n_oe  = rst_r;
    o_reset_n_out = 1'b0;
  end

  assign o_supply_margin_wide = margin_r;
endmodule

// file: srw_supervisor_props.sv
// assertions on the reset supervisor ports
`timescale 1ns/1ps
module srw_props
  import srw_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYC
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // supply and strobe side
  input wire logic i_supply_low,
  input wire logic i_supply_margin_select,
  input wire logic o_supply_margin_wide,
  input wire logic i_pushbutton_request_n,
  input wire logic i_watchdog_kick_n,
  input wire logic i_timeout_select_high,
  input wire logic i_timeout_select_low,
  // processor reset
  input wire logic o_reset,
  input wire logic o_reset_n,
  input wire logic o_reset_n_oe,
  input wire logic o_reset_n_out
);
  localparam int STR_MIN = STRETCH_MS * TICK_DIV;
  // slack for the strobe synchroniser
  localparam int WD_MIN = (WD_SHORT_MS - 1) * TICK_DIV - 10;
  logic [31:0] hi_r;
  logic [31:0] hi_nxt;
  logic [31:0] lo_r;
  logic [31:0] lo_nxt;
  logic        kick_r;
  always_comb
  begin
    hi_nxt = o_reset ? hi_r + 1 : '0;
    lo_nxt = (o_reset || (kick_r && !i_watchdog_kick_n)) ? '0 : lo_r + 1;
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hi_r   <= '0;
      lo_r   <= '0;
      kick_r <= 1'b1;
    end
    else
    begin
      hi_r   <= hi_nxt;
      lo_r   <= lo_nxt;
      kick_r <= i_watchdog_kick_n;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  compl_rst_a: assert property (o_reset_n == !o_reset)
    else $error("reset outputs not complementary");
  oe_pull_a: assert property (o_reset_n_oe == o_reset && !o_reset_n_out)
    else $error("open-drain drive wrong");
  supply_rst_a: assert property ($rose(i_supply_low) |-> ##[1:4] o_reset)
    else $error("supply low did not reset");
  supply_hold_a: assert property (i_supply_low [*4] |-> o_reset)
    else $error("reset dropped with supply low");
  margin_fwd_a: assert property ($stable(i_supply_margin_select) [*5]
    |-> o_supply_margin_wide == i_supply_margin_select)
    else $error("margin select not forwarded");
  src_clear_a: assert property ($fell(o_reset)
    |-> i_pushbutton_request_n && !i_supply_low)
    else $error("reset released with source active");
  stretch_min_a: assert property ($fell(o_reset) |-> hi_r >= STR_MIN)
    else $error("reset pulse too short");
  wd_period_a: assert property ($rose(o_reset) && i_pushbutton_request_n
    && !i_supply_low |-> lo_r >= WD_MIN)
    else $error("watchdog fired early");
  cover property ($fell(o_reset));
  cover property ($rose(o_reset) && i_pushbutton_request_n && !i_supply_low);
  cover property (!i_pushbutton_request_n && o_reset);
endmodule
bind srw_supervisor srw_props #(.TICK_DIV(TICK_DIV))
  i_srw_props (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_supply_low(i_supply_low),
  .i_supply_margin_select(i_supply_margin_select),
  .o_supply_margin_wide(o_supply_margin_wide),
  .i_pushbutton_request_n(i_pushbutton_request_n),
  .i_watchdog_kick_n(i_watchdog_kick_n),
  .i_timeout_select_high(i_timeout_select_high),
  .i_timeout_select_low(i_timeout_select_low), .o_reset(o_reset),
  .o_reset_n(o_reset_n), .o_reset_n_oe(o_reset_n_oe),
  .o_reset_n_out(o_reset_n_out));

// file: srw_supervisor_tb.sv
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
module srw_supervisor_tb;
  import srw_pkg::*;
  // shortened time base keeps the run small; counts stay as documented
  localparam int MS = 10;
  logic clk = 0, rstn = 0, sup = 1, mar = 0, btn = 1, tdh = 0, tdl = 1;
  logic run = 1, kick_n, rst, rst_n, wide;
  int num_errors = 0, num_checks = 0, cyc = 0, n;
  srw_supervisor #(.TICK_DIV(MS)) i_srw_supervisor (.i_sys_clk(clk),
    .i_resetn(rstn),
    .i_supply_low(sup), .i_supply_margin_select(mar),
    .o_supply_margin_wide(wide), .i_pushbutton_request_n(btn),
    .i_watchdog_kick_n(kick_n), .i_timeout_select_high(tdh),
    .i_timeout_select_low(tdl), .o_reset(rst), .o_reset_n(rst_n),
    .o_reset_n_oe(), .o_reset_n_out());
  srw_cpu i_srw_cpu (.i_sys_clk(clk), .i_run(run), .i_gap(100 * MS),
    .i_reset(rst), .o_kick_n(kick_n));
  initial forever #10 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // all scenarios take about 4100 ticks
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000 * MS)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  // sampled on the falling edge, away from the launch edge
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (rst !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic t_power;
    idle(10);
    chk(rst_n, 0);
    sup <= 0;
    wait_rst(0, 260 * MS);
    chk({rst, n >= 250 * MS}, 1);
  endtask
  task automatic t_supply;
    mar <= 1;
    sup <= 1;
    idle(6);
    chk({wide, rst}, 3);
    idle(10 * MS);
    chk(rst, 1);
    sup <= 0;
    mar <= 0;
    wait_rst(0, 260 * MS);
    chk({wide, rst, n >= 250 * MS}, 1);
  endtask
  task automatic t_kick;
    wait_rst(1, 400 * MS);
    chk(rst, 0);
  endtask
  task automatic t_button;
    btn <= 0;
    idle(30 * MS);
    btn <= 1;
    idle(5);
    chk(rst, 0);
    btn <= 0;
    idle(42 * MS);
    chk(rst, 1);
    idle(20 * MS);
    btn <= 1;
    wait_rst(0, 260 * MS);
    chk({rst, n >= 250 * MS}, 1);
  endtask
  task automatic t_wdog;
    int unsigned ms_t[3] = '{WD_SHORT_MS, WD_MID_MS, WD_LONG_MS};
    logic [1:0] sel_t[3] = '{2'b01, 2'b00, 2'b10};
    run <= 0;
    for (int i = 0; i < 3; i++)
    begin
      wait_rst(1, 1300 * MS);
      {tdh, tdl} <= sel_t[i];
      wait_rst(0, 260 * MS);
      wait_rst(1, 1300 * MS);
      chk(n >= (ms_t[i] - 1) * MS && n <= ms_t[i] * MS + 5, 1);
    end
  endtask
  initial
  begin
    idle(20);
    rstn <= 1;
    t_power();
    t_supply();
    t_kick();
    t_button();
    t_wdog();
    end_sim();
  end
endmodule

// file: srw_sync.sv
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module srw_sync
#(
  parameter int unsigned W = 1
)
(
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  // the button and strobe inputs idle high: every bit resets low, not to its idle value
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;
endmodule
